/* File: hw/tmic_top.v */
// tape motion interlock control: manual motion latches, safety and reel-end logic
//
// Notes on behaviour
// - reverse-drive press sets a latch held until stop, safety drop, a fast latch or automatic source
// - reverse latch set blocks forward-drive presses
// - reverse latch drives reverse actuator on, else reverse actuator off
// - stop clears reverse latch and re-enables forward-drive button
// - fast-forward press sets held latch; it blocks fast-reverse presses
// - fast-forward latch keeps forward and reverse drive latches clear
// - fast-forward moves takeup reel return to rewind path, restores on clear
// - stop clears fast-forward, re-enables fast-reverse and drive latches
// - fast-reverse press sets held latch; it blocks fast-forward presses
// - fast-reverse latch keeps forward and reverse drive latches clear
// - fast-reverse moves supply reel return to rewind path, restores on clear
// - stop clears fast-reverse, re-enables fast-forward and drive latches
// - open threading or tension-arm switch drops safety-ok and applies brakes
// - safety-ok low stops capstan, clears manual latches, removes high supply
// - safety-ok returns by itself once all those switches close again
// - shorted reel-end post starts a held pulse forcing safety-ok low
// - reel-end pulse stops motion without brakes, reels on low supply
// - reel-end pulse ends by itself after half a second
// - write ring latches write-enabled until reel removed or lever opened
// - two independent tab-detect channels for start and end of data
// - forward-drive press sets held latch, blocks reverse, forward actuator on
// - automatic source disables manual buttons, actuators follow external inputs
`timescale 1ns/1ps
`include "tmic_defs.vh"

module tmic_top #(
  parameter DEB_CYC  = (`TMIC_CLK_HZ / 1000) * `TMIC_DEBOUNCE_US / 1000,
  parameter REEL_CYC = (`TMIC_CLK_HZ / 1000) * `TMIC_REEL_END_MS,
  parameter DEB_W    = 17,
  parameter REEL_W   = 24
) (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // operator pushbuttons, high while pressed
  input  wire        fast_forward_button,
  input  wire        fast_reverse_button,
  input  wire        forward_drive_button,
  input  wire        stop_button,
  input  wire        reverse_drive_button,
  // sense switches, high while closed or shorted
  input  wire        threading_switch,
  input  wire        tension_arm_limit_a,
  input  wire        tension_arm_limit_b,
  input  wire        reel_end_post_a,
  input  wire        reel_end_post_b,
  input  wire        write_ring_switch,
  input  wire        supply_reel_present,
  input  wire        tab_sense_a,
  input  wire        tab_sense_b,
  // external command source
  input  wire        ext_forward_cmd,
  input  wire        ext_reverse_cmd,
  // actuator commands
  output reg         forward_act_on,
  output reg         forward_act_off,
  output reg         reverse_act_on,
  output reg         reverse_act_off,
  // motors, supplies and brakes
  output reg         safety_ok_relay,
  output reg         capstan_run,
  output reg         reel_supply_high,
  output reg         reel_supply_low,
  output reg         reel_brake_a,
  output reg         reel_brake_b,
  output reg         takeup_tension_contactor,
  output reg         takeup_rewind_path,
  output reg         supply_tension_contactor,
  output reg         supply_rewind_path,
  // indications
  output reg         write_enabled,
  output reg         tab_detect_a,
  output reg         tab_detect_b,
  output reg         reel_end_pulse
);

  localparam N = `TMIC_IN_N;

  // bit order follows the debounced input positions
  wire [N-1:0] raw_in;
  assign raw_in = {tab_sense_b, tab_sense_a, supply_reel_present,
                   write_ring_switch, reel_end_post_b, reel_end_post_a,
                   tension_arm_limit_b, tension_arm_limit_a,
                   threading_switch, reverse_drive_button, stop_button,
                   forward_drive_button, fast_reverse_button,
                   fast_forward_button};

  // two-stage synchroniser, then a settle counter per input
  reg  [N-1:0]     sync1_reg;
  reg  [N-1:0]     sync2_reg;
  reg  [N-1:0]     deb_reg;
  reg  [DEB_W-1:0] deb_cnt_reg [0:N-1];
  integer          i;

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= {N{1'b0}};
      sync2_reg <= {N{1'b0}};
      deb_reg   <= {N{1'b0}};
      for (i = 0; i < N; i = i + 1)
        deb_cnt_reg[i] <= {DEB_W{1'b0}};
    end
    else if (clk_en)
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      for (i = 0; i < N; i = i + 1)
      begin
        if (sync2_reg[i] == deb_reg[i])
          deb_cnt_reg[i] <= {DEB_W{1'b0}};
        else if (deb_cnt_reg[i] >= DEB_CYC[DEB_W-1:0] - 1'b1)
        begin
          deb_reg[i]     <= sync2_reg[i];
          deb_cnt_reg[i] <= {DEB_W{1'b0}};
        end
        else
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 1'b1;
      end
    end
  end

  wire ff_btn   = deb_reg[`TMIC_IN_FF];
  wire fr_btn   = deb_reg[`TMIC_IN_FR];
  wire fwd_btn  = deb_reg[`TMIC_IN_FWD];
  wire stop_btn = deb_reg[`TMIC_IN_STOP];
  wire rev_btn  = deb_reg[`TMIC_IN_REV];
  wire ring     = deb_reg[`TMIC_IN_RING];
  wire reel_in  = deb_reg[`TMIC_IN_REEL];
  wire post_any = deb_reg[`TMIC_IN_POST_A] | deb_reg[`TMIC_IN_POST_B];
  wire sw_ok    = deb_reg[`TMIC_IN_THR] & deb_reg[`TMIC_IN_TA]
                & deb_reg[`TMIC_IN_TB];

  // control register
  reg  [1:0] ctrl_reg;
  reg        soft_stop_reg;
  wire       auto_source_select = ctrl_reg[`TMIC_CTRL_AUTO];

  // motion latches and safety state
  reg               fwd_reg;
  reg               rev_reg;
  reg               ff_reg;
  reg               fr_reg;
  reg               pulse_reg;
  reg               armed_reg;
  reg  [REEL_W-1:0] reel_cnt_reg;
  reg               we_reg;

  // reel-end pulse: starts on a shorted post, re-arms only once posts clear
  wire pulse_start = post_any & armed_reg & ~pulse_reg;
  wire pulse_done  = pulse_reg
                   & (reel_cnt_reg >= REEL_CYC[REEL_W-1:0] - 1'b1);
  // high from the edge the pulse starts up to the edge it ends
  wire pulse_on    = pulse_start | (pulse_reg & ~pulse_done);

  // safety drops in the same edge as its cause, so no manual drive outlives it; external commands are not gated by it
  wire safe_next = sw_ok & ~pulse_on;

  // write latch: set by the ring, lost with the reel or an open lever
  wire we_next = (we_reg | ring) & reel_in & deb_reg[`TMIC_IN_THR];

  // manual supply: gone when automatic, stopped or safety dropped;
  // stop beats a start press that arrives in the same cycle
  wire manual_pwr = ~auto_source_select & safe_next
                  & ~stop_btn & ~soft_stop_reg;

  wire ff_next  = manual_pwr
                & (ff_reg | (ff_btn & ~fr_btn & ~fr_reg));
  wire fr_next  = manual_pwr
                & (fr_reg | (fr_btn & ~ff_btn & ~ff_reg));
  // a fast latch opens the drive latches' return in the edge it sets
  wire fast_any = ff_next | fr_next;

  wire fwd_next = manual_pwr & ~fast_any
                & (fwd_reg | (fwd_btn & ~rev_btn
                              & ~rev_reg));
  wire rev_next = manual_pwr & ~fast_any
                & (rev_reg | (rev_btn & ~fwd_btn
                              & ~fwd_reg));

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pulse_reg    <= 1'b0;
      armed_reg    <= 1'b0;
      reel_cnt_reg <= {REEL_W{1'b0}};
    end
    else if (clk_en)
    begin
      if (pulse_start)
      begin
        pulse_reg    <= 1'b1;
        armed_reg    <= 1'b0;
        reel_cnt_reg <= {REEL_W{1'b0}};
      end
      else if (pulse_done)
      begin
        pulse_reg    <= 1'b0;
        reel_cnt_reg <= {REEL_W{1'b0}};
      end
      else if (pulse_reg)
        reel_cnt_reg <= reel_cnt_reg + 1'b1;
      if (!post_any && !pulse_start)
        armed_reg <= 1'b1;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fwd_reg         <= 1'b0;
      rev_reg         <= 1'b0;
      ff_reg          <= 1'b0;
      fr_reg          <= 1'b0;
      we_reg          <= 1'b0;
      safety_ok_relay <= 1'b0;
    end
    else if (clk_en)
    begin
      fwd_reg         <= fwd_next;
      rev_reg         <= rev_next;
      ff_reg          <= ff_next;
      fr_reg          <= fr_next;
      safety_ok_relay <= safe_next;
      we_reg          <= we_next;
    end
  end

  // actuator source: manual latches or external commands, never both on;
  // the external pair is not debounced, so both high means both off
  function act_sel;
    input auto_on;
    input ext_own;
    input ext_other;
    input manual_on;
    begin
      act_sel = auto_on ? (ext_own & ~ext_other) : manual_on;
    end
  endfunction

  wire fwd_cmd = act_sel(auto_source_select, ext_forward_cmd, ext_reverse_cmd, fwd_next);
  wire rev_cmd = act_sel(auto_source_select, ext_reverse_cmd, ext_forward_cmd, rev_next);

  // registered drive outputs follow the next state of the latches
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      forward_act_on           <= 1'b0;
      forward_act_off          <= 1'b1;
      reverse_act_on           <= 1'b0;
      reverse_act_off          <= 1'b1;
      capstan_run              <= 1'b0;
      reel_supply_high         <= 1'b0;
      reel_supply_low          <= 1'b1;
      reel_brake_a             <= 1'b1;
      reel_brake_b             <= 1'b1;
      takeup_tension_contactor <= 1'b1;
      takeup_rewind_path       <= 1'b0;
      supply_tension_contactor <= 1'b1;
      supply_rewind_path       <= 1'b0;
      write_enabled            <= 1'b0;
      tab_detect_a             <= 1'b0;
      tab_detect_b             <= 1'b0;
      reel_end_pulse           <= 1'b0;
    end
    else if (clk_en)
    begin
      forward_act_on           <= fwd_cmd;
      forward_act_off          <= ~fwd_cmd;
      reverse_act_on           <= rev_cmd;
      reverse_act_off          <= ~rev_cmd;
      capstan_run              <= safe_next;
      reel_supply_high         <= safe_next;
      reel_supply_low          <= ~safe_next;
      reel_brake_a             <= ~sw_ok;
      reel_brake_b             <= ~sw_ok;
      takeup_tension_contactor <= ~ff_next;
      takeup_rewind_path       <= ff_next;
      supply_tension_contactor <= ~fr_next;
      supply_rewind_path       <= fr_next;
      write_enabled            <= we_next;
      tab_detect_a             <= deb_reg[`TMIC_IN_TAB_A];
      tab_detect_b             <= deb_reg[`TMIC_IN_TAB_B];
      reel_end_pulse           <= pulse_on;
    end
  end

  // status word
  wire [31:0] status_word;
  assign status_word = {21'h000000,
                        tab_detect_b, tab_detect_a, auto_source_select,
                        sw_ok, we_reg, pulse_reg, safety_ok_relay,
                        fr_reg, ff_reg, rev_reg, fwd_reg};

  // register port: writes take effect at once, read data one cycle later
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg      <= `TMIC_CTRL_RESET;
      soft_stop_reg <= 1'b0;
      reg_rdata     <= 32'h00000000;
    end
    else if (clk_en)
    begin
      // bit 1 of a control write is a one-cycle stop, never stored
      soft_stop_reg <= 1'b0;
      if (reg_wr && reg_addr == `TMIC_OFS_CTRL)
      begin
        ctrl_reg[`TMIC_CTRL_AUTO] <= reg_wdata[`TMIC_CTRL_AUTO];
        soft_stop_reg             <= reg_wdata[`TMIC_CTRL_STOP];
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `TMIC_OFS_CTRL:   reg_rdata <= {31'h00000000, ctrl_reg[0]};
          `TMIC_OFS_STATUS: reg_rdata <= status_word;
          default:          reg_rdata <= 32'h00000000;
        endcase
      end
      else
        reg_rdata <= 32'h00000000;
    end
  end

endmodule // tmic_top

/* File: hw/tmic_defs.vh */
// constants for the tape motion interlock control block
`ifndef TMIC_DEFS_VH
`define TMIC_DEFS_VH

// clock rate
`define TMIC_CLK_HZ        25000000
// debounce settle time in microseconds
`define TMIC_DEBOUNCE_US   5000
// reel-end pulse length in milliseconds
`define TMIC_REEL_END_MS   500

// register offsets, byte addresses
`define TMIC_ADDR_W        4
`define TMIC_OFS_CTRL      4'h0
`define TMIC_OFS_STATUS    4'h4
`define TMIC_CTRL_RESET    2'h0

// control register fields
`define TMIC_CTRL_AUTO     0
`define TMIC_CTRL_STOP     1

// status register fields
`define TMIC_ST_FWD        0
`define TMIC_ST_REV        1
`define TMIC_ST_FF         2
`define TMIC_ST_FR         3
`define TMIC_ST_SAFE       4
`define TMIC_ST_PULSE      5
`define TMIC_ST_WE         6
`define TMIC_ST_SW_OK      7
`define TMIC_ST_AUTO       8
`define TMIC_ST_TAB_A      9
`define TMIC_ST_TAB_B      10

// debounced input positions
`define TMIC_IN_FF         0
`define TMIC_IN_FR         1
`define TMIC_IN_FWD        2
`define TMIC_IN_STOP       3
`define TMIC_IN_REV        4
`define TMIC_IN_THR        5
`define TMIC_IN_TA         6
`define TMIC_IN_TB         7
`define TMIC_IN_POST_A     8
`define TMIC_IN_POST_B     9
`define TMIC_IN_RING       10
`define TMIC_IN_REEL       11
`define TMIC_IN_TAB_A      12
`define TMIC_IN_TAB_B      13
`define TMIC_IN_N          14

`endif

/* File: tb/tmic_chk.sv */
// assertion checker for the tape motion interlock block
`timescale 1ns/1ps
module tmic_chk #(
  parameter REEL_CYC = 50
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // actuator commands
  input wire forward_act_on,
  input wire forward_act_off,
  input wire reverse_act_on,
  input wire reverse_act_off,
  // motors, supplies and brakes
  input wire safety_ok_relay,
  input wire capstan_run,
  input wire reel_supply_high,
  input wire reel_supply_low,
  input wire reel_brake_a,
  input wire reel_brake_b,
  input wire takeup_tension_contactor,
  input wire takeup_rewind_path,
  input wire supply_tension_contactor,
  input wire supply_rewind_path,
  input wire reel_end_pulse
);
  int n_hi;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles the reel-end pulse has stood so far
  always @(posedge core_clk)
    if (!rst_n || !reel_end_pulse)
      n_hi <= 0;
    else if (clk_en)
      n_hi <= n_hi + 1;
  sequence pulse_start;
    $rose(reel_end_pulse);
  endsequence
  sequence trip_only;
    !safety_ok_relay && !reel_end_pulse;
  endsequence
  a_act_excl: assert property (!(forward_act_on && reverse_act_on))
    else $error("both actuators on");
  a_rev_off: assert property (reverse_act_off != reverse_act_on)
    else $error("reverse on and off commands agree");
  a_fwd_off: assert property (forward_act_off != forward_act_on)
    else $error("forward on and off commands agree");
  a_fast_excl: assert property (!(takeup_rewind_path && supply_rewind_path))
    else $error("both rewind paths selected");
  a_fast_nodrive: assert property ((takeup_rewind_path || supply_rewind_path)
    |-> !forward_act_on && !reverse_act_on) else $error("drive on during fast wind");
  a_takeup_path: assert property (takeup_tension_contactor != takeup_rewind_path)
    else $error("takeup return path wrong");
  a_supply_path: assert property (supply_tension_contactor != supply_rewind_path)
    else $error("supply return path wrong");
  a_trip_brake: assert property (trip_only |-> reel_brake_a && reel_brake_b)
    else $error("brakes released on safety trip");
  a_safe_drop: assert property (!safety_ok_relay |-> !capstan_run && !reel_supply_high)
    else $error("capstan or high supply left on");
  a_pulse_trip: assert property (reel_end_pulse
    |-> !safety_ok_relay && reel_supply_low && !capstan_run) else $error("pulse left motion on");
  a_pulse_hold: assert property (pulse_start |-> reel_end_pulse [*8])
    else $error("reel-end pulse not held");
  a_pulse_len: assert property ($fell(reel_end_pulse) && $past(rst_n)
    |-> n_hi >= REEL_CYC - 1 && n_hi <= REEL_CYC + 1) else $error("pulse length wrong");
  a_pulse_bound: assert property (n_hi <= REEL_CYC + 1)
    else $error("reel-end pulse too long");
endmodule // tmic_chk

bind tmic_top tmic_chk #(.REEL_CYC(REEL_CYC)) tmic_chk_i (.core_clk(core_clk), .rst_n(rst_n),
  .clk_en(clk_en), .forward_act_on(forward_act_on), .forward_act_off(forward_act_off),
  .reverse_act_on(reverse_act_on),
  .reverse_act_off(reverse_act_off), .safety_ok_relay(safety_ok_relay),
  .capstan_run(capstan_run), .reel_supply_high(reel_supply_high),
  .reel_supply_low(reel_supply_low), .reel_brake_a(reel_brake_a), .reel_brake_b(reel_brake_b),
  .takeup_tension_contactor(takeup_tension_contactor), .takeup_rewind_path(takeup_rewind_path),
  .supply_tension_contactor(supply_tension_contactor), .supply_rewind_path(supply_rewind_path),
  .reel_end_pulse(reel_end_pulse));

/* File: tb/tmic_panel.sv */
// operator panel and sense switch model facing the interlock block
`timescale 1ns/1ps
module tmic_panel (
  // clock
  input  wire        core_clk,
  // buttons: fast fwd, fast rev, fwd, stop, rev
  output logic [4:0] btn,
  // thread, arm a, arm b, post a, post b, ring, reel, tab a, tab b
  output logic [8:0] sw
);
  initial
  begin
    btn = 5'h00;
    sw  = 9'h047;
  end
  // momentary press with one contact bounce, then time to settle
  task automatic press(input logic [4:0] m, input int hold);
    @(posedge core_clk) btn <= m;
    @(posedge core_clk) btn <= 5'h00;
    @(posedge core_clk) btn <= m;
    repeat (hold) @(posedge core_clk);
    btn <= 5'h00;
    repeat (12) @(posedge core_clk);
  endtask
  task automatic set_sw(input logic [8:0] v);
    @(posedge core_clk) sw <= v;
    repeat (12) @(posedge core_clk);
  endtask
endmodule // tmic_panel

/* File: tb/tb.sv */
// self-checking bench for the tape motion interlock block
`timescale 1ns/1ps
module tb;
  logic        core_clk, rst_n, clk_en, reg_wr, reg_rd, ext_forward_cmd, ext_reverse_cmd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, d;
  wire  [31:0] reg_rdata;
  wire  [4:0]  btn;
  wire  [8:0]  sw;
  wire         forward_act_on, forward_act_off, reverse_act_on, reverse_act_off, safety_ok_relay,
    capstan_run, reel_supply_high, reel_supply_low, reel_brake_a, reel_brake_b, write_enabled,
    takeup_tension_contactor, takeup_rewind_path, supply_tension_contactor, supply_rewind_path,
    tab_detect_a, tab_detect_b, reel_end_pulse;
  wire  [3:0]  mot = {supply_rewind_path, takeup_rewind_path, reverse_act_on, forward_act_on};
  int          n_fail, compares, b, o, hold;
  int          pick[4] = '{0, 1, 2, 4};
  logic [4:0]  pair[3] = '{5'h14, 5'h03, 5'h0c};

  tmic_panel tmic_panel_i (.core_clk, .btn, .sw);
  tmic_top #(.DEB_CYC(4), .REEL_CYC(50)) tmic_top_i (.core_clk, .rst_n, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fast_forward_button(btn[0]),
    .fast_reverse_button(btn[1]), .forward_drive_button(btn[2]), .stop_button(btn[3]),
    .reverse_drive_button(btn[4]), .threading_switch(sw[0]), .tension_arm_limit_a(sw[1]),
    .tension_arm_limit_b(sw[2]), .reel_end_post_a(sw[3]), .reel_end_post_b(sw[4]),
    .write_ring_switch(sw[5]), .supply_reel_present(sw[6]), .tab_sense_a(sw[7]),
    .tab_sense_b(sw[8]), .ext_forward_cmd, .ext_reverse_cmd, .forward_act_on, .forward_act_off,
    .reverse_act_on, .reverse_act_off, .safety_ok_relay, .capstan_run, .reel_supply_high,
    .reel_supply_low, .reel_brake_a, .reel_brake_b, .takeup_tension_contactor,
    .takeup_rewind_path, .supply_tension_contactor, .supply_rewind_path, .write_enabled,
    .tab_detect_a, .tab_detect_b, .reel_end_pulse);

  // motion outputs expected once one button has latched
  function automatic logic [3:0] exp_of(input int k);
    case (k)
      0: return 4'h4;
      1: return 4'h8;
      2: return 4'h1;
      default: return 4'h2;
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    #1;
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_safe;
    repeat (40) if (safety_ok_relay !== 1'b1) @(posedge core_clk);
    chk(safety_ok_relay, 1);
  endtask
  task results;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // the whole sequence needs some 1500 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results;
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, ext_forward_cmd, ext_reverse_cmd} = 5'h00;
    clk_en = 1'b1;
    {reg_addr, reg_wdata} = 36'h0;
    o = $urandom(32'h6970);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_safe;
    chk({reel_brake_b, reel_brake_a, capstan_run, reel_supply_high}, 4'h3);
    repeat (8)
    begin
      b = pick[$urandom % 4];
      o = (b < 2) ? b ^ 1 : 6 - b;
      hold = 8 + $urandom % 8;
      tmic_panel_i.press(5'h01 << b, hold);
      chk(mot, exp_of(b));
      tmic_panel_i.press(5'h01 << o, hold);
      chk(mot, exp_of(b));
      tmic_panel_i.press(5'h04, hold);
      chk(mot, exp_of(b));
      tmic_panel_i.press(5'h08, hold);
      chk({forward_act_off, reverse_act_off, mot}, 6'h30);
      $display("test latch %0d done", b);
    end
    foreach (pair[i])
    begin
      tmic_panel_i.press(pair[i], 10);
      chk(mot, 4'h0);
    end
    $display("test opposing presses done");
    for (b = 0; b < 3; b++)
    begin
      tmic_panel_i.press(5'h04, 10);
      rd(4'h4);
      chk(d[10:0] & 11'h093, 11'h091);
      tmic_panel_i.set_sw(9'h047 & ~(9'h001 << b));
      chk({safety_ok_relay, reel_brake_b, reel_brake_a, capstan_run, reel_supply_high,
        forward_act_on}, 6'h18);
      tmic_panel_i.set_sw(9'h047);
      wait_safe;
      chk(forward_act_on, 0);
    end
    $display("test safety trip done");
    for (b = 3; b < 5; b++)
    begin
      tmic_panel_i.press(5'h04, 10);
      tmic_panel_i.set_sw(9'h047 | (9'h001 << b));
      chk({reel_end_pulse, safety_ok_relay, reel_brake_a, reel_supply_low, forward_act_on},
        5'h12);
      tmic_panel_i.set_sw(9'h047);
      repeat (80) if (reel_end_pulse !== 1'b0) @(posedge core_clk);
      chk(reel_end_pulse, 0);
      wait_safe;
    end
    $display("test reel end done");
    tmic_panel_i.set_sw(9'h067);
    chk(write_enabled, 1);
    tmic_panel_i.set_sw(9'h047);
    chk(write_enabled, 1);
    tmic_panel_i.set_sw(9'h007);
    chk(write_enabled, 0);
    tmic_panel_i.set_sw(9'h067);
    tmic_panel_i.set_sw(9'h066);
    chk(write_enabled, 0);
    tmic_panel_i.set_sw(9'h0c7);
    chk({tab_detect_b, tab_detect_a}, 2'h1);
    tmic_panel_i.set_sw(9'h147);
    chk({tab_detect_b, tab_detect_a}, 2'h2);
    tmic_panel_i.set_sw(9'h047);
    $display("test write ring and tabs done");
    tmic_panel_i.press(5'h04, 10);
    @(posedge core_clk);
    clk_en <= 1'b0;
    tmic_panel_i.press(5'h08, 10);
    chk(mot, 4'h1);
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(mot, 4'h1);
    wr(4'hc, $urandom);
    wr(4'h0, ($urandom & 32'hfffffffc) | 32'h2);
    repeat (2) @(posedge core_clk);
    chk(mot, 4'h0);
    rd(4'h0);
    chk(d, 0);
    $display("test freeze and soft stop done");
    wr(4'h0, 32'h1);
    rd(4'h0);
    chk(d, 32'h1);
    tmic_panel_i.press(5'h04, 10);
    chk(mot, 4'h0);
    @(posedge core_clk);
    ext_forward_cmd <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(mot, 4'h1);
    @(posedge core_clk);
    ext_reverse_cmd <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(mot, 4'h0);
    rd(4'h4);
    chk(d[8], 1);
    rd(4'h8);
    chk(d, 0);
    wr(4'h0, 32'h0);
    $display("test automatic source done");
    results;
  end
endmodule // tb
